//--- hdl/fvc_pkg.sv
`default_nettype none
package fvc_pkg;

    // ----------------------------------------------------------------
    // Serial command codes for the two configuration registers
    // ----------------------------------------------------------------
    localparam logic [7:0] FVC_CMD_WR_READ_CFG = 8'h81;
    localparam logic [7:0] FVC_CMD_RD_READ_CFG = 8'h85;
    localparam logic [7:0] FVC_CMD_WR_PROT_CFG = 8'h61;
    localparam logic [7:0] FVC_CMD_RD_PROT_CFG = 8'h65;

    // ----------------------------------------------------------------
    // Read configuration register layout
    // ----------------------------------------------------------------
    localparam int FVC_DUMMY_MSB = 7;
    localparam int FVC_DUMMY_LSB = 4;
    localparam int FVC_XIP_BIT = 3;
    localparam int FVC_RC_RSVD_BIT = 2;
    localparam int FVC_WRAP_MSB = 1;
    localparam int FVC_WRAP_LSB = 0;
    localparam logic [7:0] FVC_READ_CFG_RESET = 8'hFB;
    localparam logic [7:0] FVC_READ_CFG_MASK = 8'hFB;
    localparam logic [3:0] FVC_DUMMY_CODE_ZERO = 4'h0;
    localparam logic [3:0] FVC_DUMMY_CODE_ONES = 4'hF;

    // ----------------------------------------------------------------
    // Protocol configuration register layout
    // ----------------------------------------------------------------
    localparam int FVC_QUAD_BIT = 7;
    localparam int FVC_DUAL_BIT = 6;
    localparam int FVC_PC_RSVD_BIT = 5;
    localparam int FVC_HOLD_BIT = 4;
    localparam int FVC_ACCEL_BIT = 3;
    localparam int FVC_DRIVE_MSB = 2;
    localparam int FVC_DRIVE_LSB = 0;
    localparam logic [7:0] FVC_PROT_CFG_RESET = 8'hDF;
    localparam logic [7:0] FVC_PROT_CFG_MASK = 8'hDF;

    // ----------------------------------------------------------------
    // Power-on strap positions in the nonvolatile word
    // ----------------------------------------------------------------
    localparam int FVC_NV_QUAD_BIT = 3;
    localparam int FVC_NV_DUAL_BIT = 2;

    // ----------------------------------------------------------------
    // Wrap codes and link counters
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FVC_WRAP_16 = 2'b00,
        FVC_WRAP_32 = 2'b01,
        FVC_WRAP_64 = 2'b10,
        FVC_WRAP_SEQ = 2'b11
    } fvc_wrap_e;
    localparam logic [2:0] FVC_BIT_LAST = 3'h7;
    localparam logic [3:0] FVC_DEFAULT_DUMMY = 4'hA;

endpackage : fvc_pkg
`default_nettype wire

//--- hdl/fvc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module fvc_config_regs
    import fvc_pkg::*;
#(
    parameter bit XIP_ALWAYS = 1'b0,
    parameter logic [3:0] DEFAULT_DUMMY = FVC_DEFAULT_DUMMY
) (
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic SER_CLK_IN,
    input wire logic SER_CS_N_IN,
    input wire logic SER_DATA_IN,
    output logic SER_DATA_OUT,
    output logic SER_DATA_OE_OUT,
    input wire logic [1:0] NV_PROTOCOL_IN,
    input wire logic READ_START_IN,
    input wire logic [23:0] READ_ADDR_IN,
    input wire logic READ_NEXT_IN,
    output logic [23:0] READ_ADDR_OUT,
    output logic [3:0] DUMMY_CYCLES_OUT,
    output logic EXECUTE_IN_PLACE_OUT,
    output logic [1:0] WRAP_MODE_OUT,
    output logic QUAD_IO_OUT,
    output logic DUAL_IO_OUT,
    output logic HOLD_RESET_EN_OUT,
    output logic PROG_ACCEL_EN_OUT,
    output logic [2:0] DRIVE_STRENGTH_OUT,
    output logic [7:0] READ_CFG_OUT,
    output logic [7:0] PROT_CFG_OUT
);

    // ------------------------------------------------------------
    // Link domain: command shifter on the serial clock
    // ------------------------------------------------------------
    logic link_rst;
    logic [2:0] bit_cnt;
    logic data_phase;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic byte_done;
    logic [7:0] next_shift;
    logic wr_done;
    logic wr_tgl;
    logic wr_sel_prot;
    logic [7:0] wr_data;
    logic [15:0] rd_sync1;
    logic [15:0] rd_sync2;
    logic [7:0] rd_word;
    logic cmd_is_read;
    logic cmd_is_write;
    logic dout;

    // Frame end or global reset clears the frame state
    assign link_rst = SER_CS_N_IN | ~ARST_N_IN;
    assign next_shift = {shift[6:0], SER_DATA_IN};
    assign byte_done = (bit_cnt == FVC_BIT_LAST);
    assign cmd_is_write = (cmd == FVC_CMD_WR_READ_CFG) || (cmd == FVC_CMD_WR_PROT_CFG);
    assign cmd_is_read = (cmd == FVC_CMD_RD_READ_CFG) || (cmd == FVC_CMD_RD_PROT_CFG);
    assign rd_word = (cmd == FVC_CMD_RD_PROT_CFG) ? rd_sync2[15:8] : rd_sync2[7:0];

    // Bit counter, command byte and phase
    always_ff @(posedge SER_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= 3'h0;
            data_phase <= 1'b0;
            shift <= 8'h00;
            cmd <= 8'h00;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shift <= next_shift;
            if (byte_done && !data_phase) begin
                cmd <= next_shift;
                data_phase <= 1'b1;
            end
        end
    end

    // Only the first data byte of a write frame is taken
    always_ff @(posedge SER_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            wr_done <= 1'b0;
        end else if (data_phase && byte_done && cmd_is_write) begin
            wr_done <= 1'b1;
        end
    end

    // Write data held until the next write; event sent as toggle
    always_ff @(posedge SER_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            wr_tgl <= 1'b0;
            wr_sel_prot <= 1'b0;
            wr_data <= 8'h00;
        end else if (!SER_CS_N_IN && data_phase && byte_done && cmd_is_write && !wr_done) begin
            wr_tgl <= ~wr_tgl;
            wr_sel_prot <= (cmd == FVC_CMD_WR_PROT_CFG);
            wr_data <= next_shift;
        end
    end

    // Register contents brought into the link domain for read-back
    always_ff @(posedge SER_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rd_sync1 <= {FVC_PROT_CFG_RESET, FVC_READ_CFG_RESET};
            rd_sync2 <= {FVC_PROT_CFG_RESET, FVC_READ_CFG_RESET};
        end else begin
            rd_sync1 <= {PROT_CFG_OUT, READ_CFG_OUT};
            rd_sync2 <= rd_sync1;
        end
    end

    // Read data shifted out MSB first on the falling edge, byte repeats
    always_ff @(negedge SER_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            dout <= 1'b0;
        end else begin
            dout <= rd_word[FVC_BIT_LAST - bit_cnt];
        end
    end

    assign SER_DATA_OUT = dout;
    assign SER_DATA_OE_OUT = !SER_CS_N_IN && data_phase && cmd_is_read;

    // ------------------------------------------------------------
    // Core domain: write event crossing
    // ------------------------------------------------------------
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic wr_evt;

    // Three-stage toggle synchroniser, edge seen between stages 2 and 3
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end else begin
            tgl_s1 <= wr_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    assign wr_evt = tgl_s2 ^ tgl_s3;

    // ------------------------------------------------------------
    // Core domain: configuration registers
    // ------------------------------------------------------------
    logic [7:0] read_config_volatile;
    logic [7:0] protocol_config_volatile;
    logic strap_done;
    logic wr_read_cfg;
    logic wr_prot_cfg;

    assign wr_read_cfg = wr_evt && !wr_sel_prot;
    assign wr_prot_cfg = wr_evt && wr_sel_prot;

    // Read configuration register, takes effect on write completion
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            read_config_volatile <= FVC_READ_CFG_RESET;
        end else if (wr_read_cfg) begin
            read_config_volatile <= wr_data & FVC_READ_CFG_MASK;
        end
    end

    // Protocol register: strap loaded once after reset release
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            protocol_config_volatile <= FVC_PROT_CFG_RESET;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            protocol_config_volatile[FVC_QUAD_BIT] <= NV_PROTOCOL_IN[1];
            protocol_config_volatile[FVC_DUAL_BIT] <= NV_PROTOCOL_IN[0];
        end else if (wr_prot_cfg) begin
            protocol_config_volatile <= wr_data & FVC_PROT_CFG_MASK;
        end
    end

    assign READ_CFG_OUT = read_config_volatile;
    assign PROT_CFG_OUT = protocol_config_volatile;

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    logic [3:0] dummy_code;
    logic dummy_is_default;

    assign dummy_code = read_config_volatile[FVC_DUMMY_MSB:FVC_DUMMY_LSB];
    assign dummy_is_default = (dummy_code == FVC_DUMMY_CODE_ZERO) || (dummy_code == FVC_DUMMY_CODE_ONES);
    assign DUMMY_CYCLES_OUT = dummy_is_default ? DEFAULT_DUMMY : dummy_code;
    assign EXECUTE_IN_PLACE_OUT = XIP_ALWAYS || !read_config_volatile[FVC_XIP_BIT];
    assign WRAP_MODE_OUT = read_config_volatile[FVC_WRAP_MSB:FVC_WRAP_LSB];
    assign QUAD_IO_OUT = !protocol_config_volatile[FVC_QUAD_BIT];
    assign DUAL_IO_OUT = protocol_config_volatile[FVC_QUAD_BIT] && !protocol_config_volatile[FVC_DUAL_BIT];
    assign HOLD_RESET_EN_OUT = protocol_config_volatile[FVC_HOLD_BIT];
    assign PROG_ACCEL_EN_OUT = !protocol_config_volatile[FVC_ACCEL_BIT];
    assign DRIVE_STRENGTH_OUT = protocol_config_volatile[FVC_DRIVE_MSB:FVC_DRIVE_LSB];

    // ------------------------------------------------------------
    // Read address sequencer with wrap
    // ------------------------------------------------------------
    logic [23:0] read_addr;
    logic [23:0] wrap_mask;
    logic [23:0] addr_inc;
    logic [23:0] next_read_addr;

    assign wrap_mask = (WRAP_MODE_OUT == FVC_WRAP_16) ? 24'h00000F :
                       (WRAP_MODE_OUT == FVC_WRAP_32) ? 24'h00001F :
                       (WRAP_MODE_OUT == FVC_WRAP_64) ? 24'h00003F : 24'hFFFFFF;
    assign addr_inc = read_addr + 24'h000001;
    assign next_read_addr = (read_addr & ~wrap_mask) | (addr_inc & wrap_mask);

    // Start loads the address; each step advances within the block, or through all 24 address bits in sequential mode
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            read_addr <= 24'h000000;
        end else if (READ_START_IN) begin
            read_addr <= READ_ADDR_IN;
        end else if (READ_NEXT_IN) begin
            read_addr <= next_read_addr;
        end
    end

    assign READ_ADDR_OUT = read_addr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wrap16_step_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (!READ_START_IN && READ_NEXT_IN && WRAP_MODE_OUT == FVC_WRAP_16 && read_addr[3:0] == 4'hF)
        |=> (read_addr[3:0] == 4'h0 && read_addr[23:4] == $past(read_addr[23:4])))
        else $error("16-byte wrap did not return to block start");

    seq_step_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (!READ_START_IN && READ_NEXT_IN && WRAP_MODE_OUT == FVC_WRAP_SEQ)
        |=> (read_addr == $past(read_addr) + 24'h000001))
        else $error("sequential read did not increment");

    start_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        READ_START_IN |=> (read_addr == $past(READ_ADDR_IN)))
        else $error("read start address not loaded");

    dummy_default_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (read_config_volatile[7:4] == 4'h0 || read_config_volatile[7:4] == 4'hF)
        |-> (DUMMY_CYCLES_OUT == DEFAULT_DUMMY))
        else $error("default dummy code not mapped");

    dummy_field_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (read_config_volatile[7:4] != 4'h0 && read_config_volatile[7:4] != 4'hF)
        |-> (DUMMY_CYCLES_OUT == read_config_volatile[7:4]))
        else $error("dummy count differs from field");

    quad_wins_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (protocol_config_volatile[7:6] == 2'b00) |-> (QUAD_IO_OUT && !DUAL_IO_OUT))
        else $error("quad did not win over dual");

    strap_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        $rose(strap_done) |-> (protocol_config_volatile[7:6] == $past(NV_PROTOCOL_IN)))
        else $error("power-on protocol not taken from straps");

    write_apply_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (strap_done && $changed(tgl_s2)) |=> ##1 (wr_sel_prot ? (PROT_CFG_OUT == (wr_data & 8'hDF))
                                                    : (READ_CFG_OUT == (wr_data & 8'hFB))))
        else $error("register write not applied two cycles after sync");

    reserved_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (!READ_CFG_OUT[2] && !PROT_CFG_OUT[5]))
        else $error("reserved bit read as one");

    xip_select_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        EXECUTE_IN_PLACE_OUT == (XIP_ALWAYS || !read_config_volatile[3]))
        else $error("execute-in-place select wrong");

    read_cfg_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        !wr_read_cfg |=> $stable(read_config_volatile))
        else $error("read configuration changed without a write");

    prot_cfg_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (strap_done && !wr_prot_cfg) |=> $stable(protocol_config_volatile))
        else $error("protocol configuration changed without a write");

    dual_select_a: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
        (protocol_config_volatile[7:6] == 2'b10) |-> (DUAL_IO_OUT && !QUAD_IO_OUT))
        else $error("dual protocol not selected");

endmodule // fvc_config_regs
`default_nettype wire

//--- bench/fvc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fvc_host_model (
    output logic ser_clk_out,
    output logic ser_cs_n_out,
    output logic ser_data_out,
    input wire logic ser_data_in,
    input wire logic ser_data_oe_in
);
    // ------------------------------------------------------------
    // Idle state: clock parked low, select high
    // ------------------------------------------------------------
    initial begin
        ser_clk_out = 1'b0;
        ser_cs_n_out = 1'b1;
        ser_data_out = 1'b0;
    end

    // One bit per 64 ns: data set after falls, reply taken at rises.
    // Register access needs no dummy cycles, so clock stays legal
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata, input int n_bits,
                        output logic [15:0] rdata);
        logic [23:0] sh;
        sh = {cmd, wdata};
        rdata = 16'h0000;
        #71; // Select stays high for a while between frames
        ser_cs_n_out = 1'b0;
        for (int i = 0; i < n_bits; i++) begin
            ser_data_out = sh[23];
            sh = {sh[22:0], 1'b0};
            #32;
            ser_clk_out = 1'b1;
            if (i >= 8) begin
                rdata = {rdata[14:0], ser_data_in & ser_data_oe_in};
            end
            #32;
            ser_clk_out = 1'b0;
        end
        #32;
        ser_cs_n_out = 1'b1;
        ser_data_out = ~ser_data_out; // Released line shows no stale bit
    endtask
endmodule // fvc_host_model
`default_nettype wire

//--- bench/fvc_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fvc_config_regs_bench;
    import fvc_pkg::*;
    logic core_clk, arst_n, ser_clk, ser_cs_n, ser_din, ser_dout, ser_oe;
    logic [1:0] nv_prot;
    logic read_start, read_next;
    logic [23:0] read_addr, addr_out;
    logic [3:0] dummy;
    logic execute_in_place, quad, dual, hold_en, accel;
    logic [1:0] wrap;
    logic [2:0] drive;
    logic [7:0] rcfg, pcfg;
    logic [15:0] rd;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Design and host
    // ------------------------------------------------------------
    fvc_config_regs u_dut (.CORE_CLK_IN(core_clk), .ARST_N_IN(arst_n), .SER_CLK_IN(ser_clk),
        .SER_CS_N_IN(ser_cs_n), .SER_DATA_IN(ser_din), .SER_DATA_OUT(ser_dout),
        .SER_DATA_OE_OUT(ser_oe), .NV_PROTOCOL_IN(nv_prot), .READ_START_IN(read_start),
        .READ_ADDR_IN(read_addr), .READ_NEXT_IN(read_next), .READ_ADDR_OUT(addr_out),
        .DUMMY_CYCLES_OUT(dummy), .EXECUTE_IN_PLACE_OUT(execute_in_place), .WRAP_MODE_OUT(wrap),
        .QUAD_IO_OUT(quad), .DUAL_IO_OUT(dual), .HOLD_RESET_EN_OUT(hold_en),
        .PROG_ACCEL_EN_OUT(accel), .DRIVE_STRENGTH_OUT(drive), .READ_CFG_OUT(rcfg),
        .PROT_CFG_OUT(pcfg));
    fvc_host_model u_host (.ser_clk_out(ser_clk), .ser_cs_n_out(ser_cs_n), .ser_data_out(ser_din),
        .ser_data_in(ser_dout), .ser_data_oe_in(ser_oe));

    // Core clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] val);
        u_host.xfer(cmd, {val, ~val}, 24, rd); // Second byte must be ignored
        repeat (5) @(negedge core_clk);
    endtask

    // Reads two copies of the byte in one frame
    task automatic read_check(input logic [7:0] cmd, input logic [7:0] exp);
        u_host.xfer(cmd, 16'h0000, 24, rd);
        check(rd[15:8], exp);
        check(rd[7:0], exp);
    endtask

    task automatic power_on(input logic [1:0] nv);
        @(negedge core_clk);
        arst_n = 1'b0;
        nv_prot = nv;
        repeat (16) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        nv_prot = ~nv; // Late strap change must wait for next power-on
        repeat (2) @(negedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_power_on();
        for (int i = 0; i < 4; i++) begin
            power_on(i[1:0]);
            check(pcfg, {i[1:0], 6'h1F});
            check(quad, !i[1]);
            check(dual, i[1] && !i[0]);
            check(dummy, FVC_DEFAULT_DUMMY);
            check(wrap, 2'b11);
            check(execute_in_place, 1'b0);
            check(hold_en, 1'b1);
            check(accel, 1'b0);
        end
    endtask

    task automatic test_read_cfg();
        logic [7:0] v;
        for (int c = 0; c < 16; c++) begin
            v = {c[3:0], c[0], 1'b1, c[2:1]};
            write_reg(FVC_CMD_WR_READ_CFG, v);
            check(rcfg, v & 8'hFB);
            check(dummy, (c == 0 || c == 15) ? FVC_DEFAULT_DUMMY : c[3:0]);
            check(execute_in_place, !v[3]);
            check(wrap, v[1:0]);
            read_check(FVC_CMD_RD_READ_CFG, v & 8'hFB);
        end
        u_host.xfer(FVC_CMD_WR_READ_CFG, 16'h0000, 12, rd);
        repeat (5) @(negedge core_clk);
        check(rcfg, 8'hFB);
        u_host.xfer(8'h7E, 16'h0000, 24, rd);
        check(rd, 16'h0000);
    endtask

    task automatic test_prot_cfg();
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            v = {c[1:0], 1'b1, c[2], c[0], c[2:0]};
            write_reg(FVC_CMD_WR_PROT_CFG, v);
            check(pcfg, v & 8'hDF);
            check(quad, !v[7]);
            check(dual, v[7] && !v[6]);
            check(hold_en, v[4]);
            check(accel, !v[3]);
            check(drive, v[2:0]);
            read_check(FVC_CMD_RD_PROT_CFG, v & 8'hDF);
        end
    endtask

    task automatic test_wrap();
        logic [23:0] a;
        logic [23:0] sz;
        for (int w = 0; w < 4; w++) begin
            write_reg(FVC_CMD_WR_READ_CFG, {6'h02, w[1:0]});
            a = 24'h12343D;
            sz = (w == 3) ? 24'h000000 : (24'h000010 << w); // Block size, zero for sequential
            read_addr = a;
            read_start = 1'b1;
            @(negedge core_clk);
            read_start = 1'b0;
            read_next = 1'b1;
            check(addr_out, a);
            for (int s = 0; s < 70; s++) begin
                a = (sz == 24'h000000) ? a + 24'h000001 : a - (a % sz) + (((a % sz) + 24'h000001) % sz);
                @(negedge core_clk);
                check(addr_out, a);
            end
            read_next = 1'b0;
            @(negedge core_clk);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        nv_prot = 2'b11;
        read_start = 1'b0;
        read_next = 1'b0;
        read_addr = 24'h000000;
        test_power_on();
        test_read_cfg();
        test_prot_cfg();
        test_wrap();
        give_verdict();
    end
endmodule // fvc_config_regs_bench
`default_nettype wire
